// ---- core/addr_map_defines.svh ----
// Address map constants for the physical address decoder.
// Assumes inclusion by bare name from design files.
`ifndef ADDR_MAP_DEFINES_SVH
`define ADDR_MAP_DEFINES_SVH
`define PA_W            40
`define HA_W            64
`define PAGE_HI         38
`define PAGE_LO         34
`define PAGE_CNT        32
`define SLICE_HI        35
`define SLICE_LO        34
`define LOCAL_HI        39
`define LOCAL_LO        36
`define LICW_BASE_RST   40'h00fee00000
`define LICW_SHIFT      12
`define BOOT_BASE       40'h00ff000000
`define BOOT_TOP        40'h00ffffffff
`define SIU_BASE        40'h08007d0000
`define CRU_BASE        40'h08007c0000
`define REG_WIN_SHIFT   16
`define APER_BASE_RST   40'h0000000000
`define PWIN_MAX_LOG2   35
`define PWIN_MIN_LOG2   28
`define RWIN_LOG2       17
`define RWIN_SIU_OFF    17'h10000
`endif

// ---- core/addr_map_pkg.sv ----
// Types shared by the physical address decoder.
// Assumes no surroundings.
package addr_map_pkg;
   typedef enum logic [7:0] {
      TGT_NONE  = 8'h01,
      TGT_MEM   = 8'h02,
      TGT_LIC   = 8'h04,
      TGT_BOOT  = 8'h08,
      TGT_CRU   = 8'h10,
      TGT_SIU   = 8'h20,
      TGT_HOST  = 8'h40,
      TGT_ERR   = 8'h80
   } target_t;
   typedef struct packed {
      logic [29:0] host_hi;
      logic        no_snoop;
   } spt_entry_t;
endpackage

// ---- core/phys_addr_map_decoder.sv ----
// Physical address decoder: core requests, host inbound window accesses.
// Assumes a single clock, synchronous reset, and table/base inputs from same-clock logic.
// Notes on behaviour
// - Core physical addresses are 40 bits, 1024 GiB decodable.
// - Regions: 64 GiB local, 448 GiB reserved, 512 GiB system on top.
// - Local region is four 16 GiB slices: memory, memory, registers, reserved.
// - Relocatable 4 kB interrupt controller window overrides low local memory.
// - Top 16 MB below 4 GiB goes to boot flash and fuses.
// - Second slice is memory only at or below the programmed local memory top.
// - System region holds 32 pages of 16 GB for host memory.
// - Peer and host link requests come only from the system region.
// - System accesses translate 40-bit address to 64-bit host address.
// - Host requests are snooped unless the page entry no-snoop bit is set.
// - Inbound host accesses are snooped only when target is cacheable.
// - Prefetchable window relocatable, size 256 MiB to 32 GiB from flash.
// - Prefetchable window accesses are offset by the aperture physical base.
// - Register window is 128 KiB: companion unit at 0, interface unit at 64 KiB.
// - Interface unit registers 64 kB; host reaches them only with host_secure_ok_in set.
`include "addr_map_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module phys_addr_map_decoder
   import addr_map_pkg::*;
(
   input  wire logic                    clk_in,
   input  wire logic                    srst_in,
   input  wire logic                    req_valid_in,
   input  wire logic [`PA_W-1:0]        req_addr_in,
   input  wire logic [`PA_W-1:0]        local_memory_top_in,
   input  wire logic [27:0]             lic_base_page_in,
   input  wire logic                    lic_base_load_in,
   input  wire logic [4:0]              spt_wr_index_in,
   input  wire logic [30:0]             spt_wr_data_in,
   input  wire logic                    spt_wr_en_in,
   input  wire logic                    host_valid_in,
   input  wire logic [`HA_W-1:0]        host_addr_in,
   input  wire logic                    host_cacheable_in,
   input  wire logic                    host_secure_ok_in,
   input  wire logic [`HA_W-1:0]        pwin_base_in,
   input  wire logic [2:0]              pwin_size_sel_in,
   input  wire logic [`HA_W-1:0]        rwin_base_in,
   input  wire logic [`PA_W-1:0]        aperture_physical_base_in,
   output logic                         out_valid_out,
   output addr_map_pkg::target_t        out_target_out,
   output logic [`PA_W-1:0]             out_local_addr_out,
   output logic [`HA_W-1:0]             out_host_addr_out,
   output logic                         out_no_snoop_out,
   output logic                         in_valid_out,
   output addr_map_pkg::target_t        in_target_out,
   output logic [`PA_W-1:0]             in_local_addr_out,
   output logic                         in_snoop_out
);
   import addr_map_pkg::*;

   logic [30:0]      spt_mem [`PAGE_CNT];
   logic [27:0]      lic_page_r;
   target_t          tgt_nxt;
   target_t          itgt_nxt;
   logic [`PA_W-1:0] iaddr_nxt;
   logic [`HA_W-1:0] pwin_off;
   logic [`HA_W-1:0] rwin_off;
   logic [`HA_W-1:0] pwin_mask;
   logic [5:0]       pwin_log2;
   spt_entry_t       ent;

   // Page table storage.
   always_ff @(posedge clk_in) begin
      if (spt_wr_en_in) begin
         spt_mem[spt_wr_index_in] <= spt_wr_data_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         lic_page_r <= 28'(`LICW_BASE_RST >> `LICW_SHIFT);
      end else if (lic_base_load_in) begin
         lic_page_r <= lic_base_page_in;
      end
   end

   assign ent = spt_entry_t'(spt_mem[req_addr_in[`PAGE_HI:`PAGE_LO]]);

   // Outbound decode of core requests.
   always_comb begin
      tgt_nxt = TGT_ERR;
      if (req_addr_in[`PA_W-1]) begin
         tgt_nxt = TGT_HOST;
      end else if (req_addr_in[`LOCAL_HI-1:`LOCAL_LO] != 3'h0) begin
         tgt_nxt = TGT_ERR;
      end else begin
         case (req_addr_in[`SLICE_HI:`SLICE_LO])
            2'h0: begin
               if (req_addr_in[`PA_W-1:`LICW_SHIFT] == lic_page_r) begin
                  tgt_nxt = TGT_LIC;
               end else if (req_addr_in >= `BOOT_BASE && req_addr_in <= `BOOT_TOP) begin
                  tgt_nxt = TGT_BOOT;
               end else begin
                  tgt_nxt = TGT_MEM;
               end
            end
            2'h1: tgt_nxt = (req_addr_in <= local_memory_top_in) ? TGT_MEM : TGT_ERR;
            2'h2: begin
               if (req_addr_in[`PA_W-1:`REG_WIN_SHIFT] == 24'(`SIU_BASE >> `REG_WIN_SHIFT)) begin
                  tgt_nxt = TGT_SIU;
               end else if (req_addr_in[`PA_W-1:`REG_WIN_SHIFT] == 24'(`CRU_BASE >> `REG_WIN_SHIFT)) begin
                  tgt_nxt = TGT_CRU;
               end else begin
                  tgt_nxt = TGT_ERR;
               end
            end
            default: tgt_nxt = TGT_ERR;
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         out_valid_out      <= 1'b0;
         out_target_out     <= TGT_NONE;
         out_local_addr_out <= '0;
         out_host_addr_out  <= '0;
         out_no_snoop_out   <= 1'b0;
      end else begin
         out_valid_out      <= req_valid_in;
         out_target_out     <= req_valid_in ? tgt_nxt : TGT_NONE;
         out_local_addr_out <= req_addr_in;
         out_host_addr_out  <= {ent.host_hi, req_addr_in[`PAGE_LO-1:0]};
         out_no_snoop_out   <= req_valid_in && (tgt_nxt == TGT_HOST) && ent.no_snoop;
      end
   end

   // Inbound decode of host window accesses.
   always_comb begin
      pwin_log2 = 6'(`PWIN_MIN_LOG2) + 6'(pwin_size_sel_in);
      pwin_mask = ({`HA_W{1'b1}} << pwin_log2);
      pwin_off  = host_addr_in - pwin_base_in;
      rwin_off  = host_addr_in - rwin_base_in;
      itgt_nxt  = TGT_ERR;
      iaddr_nxt = '0;
      if ((pwin_off & pwin_mask) == '0) begin
         itgt_nxt  = TGT_MEM;
         iaddr_nxt = aperture_physical_base_in + pwin_off[`PA_W-1:0];
      end else if (rwin_off[`HA_W-1:`RWIN_LOG2] == '0) begin
         if (rwin_off[`RWIN_LOG2-1:0] >= `RWIN_SIU_OFF) begin
            itgt_nxt  = host_secure_ok_in ? TGT_SIU : TGT_ERR;
            iaddr_nxt = `SIU_BASE + 40'(rwin_off[15:0]);
         end else begin
            itgt_nxt  = TGT_CRU;
            iaddr_nxt = `CRU_BASE + 40'(rwin_off[15:0]);
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         in_valid_out      <= 1'b0;
         in_target_out     <= TGT_NONE;
         in_local_addr_out <= '0;
         in_snoop_out      <= 1'b0;
      end else begin
         in_valid_out      <= host_valid_in;
         in_target_out     <= host_valid_in ? itgt_nxt : TGT_NONE;
         in_local_addr_out <= iaddr_nxt;
         in_snoop_out      <= host_valid_in && (itgt_nxt == TGT_MEM) && host_cacheable_in;
      end
   end

   AST_SYS_HOST: assert property (@(posedge clk_in) disable iff (srst_in)
      req_valid_in && req_addr_in[39] |=> out_target_out == TGT_HOST)
      else $error("System address not sent to host.");
   AST_HOST_ONLY_SYS: assert property (@(posedge clk_in) disable iff (srst_in)
      out_target_out == TGT_HOST |-> $past(req_addr_in[39]))
      else $error("Host request from non-system address.");
   AST_RESV: assert property (@(posedge clk_in) disable iff (srst_in)
      req_valid_in && !req_addr_in[39] && req_addr_in[38:36] != 3'h0 |=> out_target_out == TGT_ERR)
      else $error("Reserved range not refused.");
   AST_PASS: assert property (@(posedge clk_in) disable iff (srst_in)
      req_valid_in |=> out_host_addr_out[33:0] == $past(req_addr_in[33:0]))
      else $error("Low address bits changed.");
   AST_TOP: assert property (@(posedge clk_in) disable iff (srst_in)
      req_valid_in && req_addr_in[39:34] == 6'h01 && req_addr_in > local_memory_top_in
      |=> out_target_out == TGT_ERR)
      else $error("Memory above top accepted.");
   AST_BOOT: assert property (@(posedge clk_in) disable iff (srst_in)
      req_valid_in && req_addr_in[39:24] == 16'h00ff && req_addr_in[39:12] != lic_page_r
      |=> out_target_out == TGT_BOOT)
      else $error("Boot range misrouted.");
   AST_SLICE3: assert property (@(posedge clk_in) disable iff (srst_in)
      req_valid_in && req_addr_in[39:34] == 6'h03 |=> out_target_out == TGT_ERR)
      else $error("Reserved slice accepted.");
   AST_NOSNOOP: assert property (@(posedge clk_in) disable iff (srst_in)
      out_no_snoop_out |-> out_target_out == TGT_HOST)
      else $error("No-snoop on non-host request.");
   AST_INSNOOP: assert property (@(posedge clk_in) disable iff (srst_in)
      host_valid_in && !host_cacheable_in |=> !in_snoop_out)
      else $error("Uncacheable inbound snooped.");
   // Steps of a system-region request and its answer one cycle later.
   sequence seq_sys_req;
      req_valid_in && req_addr_in[39];
   endsequence
   sequence seq_host_answer;
      out_valid_out && out_target_out == TGT_HOST;
   endsequence
   AST_SYS_PAGE: assert property (@(posedge clk_in) disable iff (srst_in)
      seq_sys_req |=> seq_host_answer)
      else $error("System page request not answered to host.");
   AST_XLATE: assert property (@(posedge clk_in) disable iff (srst_in)
      seq_sys_req |=> out_host_addr_out[63:34] == $past(ent.host_hi))
      else $error("Host address upper bits not from page entry.");
   AST_NOSNOOP_SET: assert property (@(posedge clk_in) disable iff (srst_in)
      req_valid_in && req_addr_in[39] && ent.no_snoop |=> out_no_snoop_out)
      else $error("No-snoop page entry not honoured.");
   AST_LIC: assert property (@(posedge clk_in) disable iff (srst_in)
      req_valid_in && req_addr_in[39:34] == 6'h00 && req_addr_in[39:12] == lic_page_r
      |=> out_target_out == TGT_LIC)
      else $error("Interrupt window not decoded.");
   AST_SIU_GUARD: assert property (@(posedge clk_in) disable iff (srst_in)
      in_target_out == TGT_SIU |-> $past(host_secure_ok_in))
      else $error("Host reached interface unit without permission.");
   AST_IN_VALID: assert property (@(posedge clk_in) disable iff (srst_in)
      host_valid_in |=> in_valid_out)
      else $error("Inbound request lost.");
endmodule
`default_nettype wire

// ---- testbench/host_link_model.sv ----
// Host link model: issues inbound window accesses to the decoder.
// Assumes the decoder samples on the rising edge of the shared clock.
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
   input  wire logic        clk_in,
   output logic             host_valid_out,
   output logic [63:0]      host_addr_out,
   output logic             host_cacheable_out,
   output logic             host_secure_ok_out
);
   initial begin
      host_valid_out     = 1'b0;
      host_addr_out      = 64'h0;
      host_cacheable_out = 1'b0;
      host_secure_ok_out = 1'b0;
   end
   // One request lasts one cycle; the address is scrambled once released.
   task automatic send(input logic [63:0] a, input logic c, input logic s);
      @(negedge clk_in);
      host_valid_out     = 1'b1;
      host_addr_out      = a;
      host_cacheable_out = c;
      host_secure_ok_out = s;
      @(negedge clk_in);
      host_valid_out = 1'b0;
      host_addr_out  = ~a;
   endtask
endmodule
`default_nettype wire

// ---- testbench/phys_addr_map_decoder_tb.sv ----
// Self-checking testbench for the physical address decoder.
// Assumes registered outputs one cycle after each request.
`timescale 1ns/1ps
`default_nettype none
module phys_addr_map_decoder_tb;
   import addr_map_pkg::*;
   logic clk_in = 1'b0, srst_in = 1'b1, req_valid_in = 1'b0;
   logic lic_base_load_in = 1'b0, spt_wr_en_in = 1'b0;
   logic host_valid_in, host_cacheable_in, host_secure_ok_in;
   logic [39:0] req_addr_in = '0, local_memory_top_in = 40'h05ffffffff;
   logic [39:0] aperture_physical_base_in = 40'h0000100000;
   logic [27:0] lic_base_page_in = 28'h00fee00;
   logic [4:0]  spt_wr_index_in = '0;
   logic [30:0] spt_wr_data_in = '0;
   logic [63:0] host_addr_in, pwin_base_in = 64'h40_0000_0000;
   logic [63:0] rwin_base_in = 64'h50_0000_0000;
   logic [2:0]  pwin_size_sel_in = 3'h0;
   logic out_valid_out, out_no_snoop_out, in_valid_out, in_snoop_out;
   target_t out_target_out, in_target_out;
   logic [39:0] out_local_addr_out, in_local_addr_out;
   logic [63:0] out_host_addr_out;
   int num_errors = 0, num_checks = 0;
   always #5 clk_in = ~clk_in;
   phys_addr_map_decoder dut (.clk_in, .srst_in, .req_valid_in, .req_addr_in,
      .local_memory_top_in, .lic_base_page_in, .lic_base_load_in, .spt_wr_index_in,
      .spt_wr_data_in, .spt_wr_en_in, .host_valid_in, .host_addr_in, .host_cacheable_in,
      .host_secure_ok_in, .pwin_base_in, .pwin_size_sel_in, .rwin_base_in,
      .aperture_physical_base_in, .out_valid_out, .out_target_out, .out_local_addr_out,
      .out_host_addr_out, .out_no_snoop_out, .in_valid_out, .in_target_out,
      .in_local_addr_out, .in_snoop_out);
   host_link_model host (.clk_in, .host_valid_out(host_valid_in), .host_addr_out(host_addr_in),
      .host_cacheable_out(host_cacheable_in), .host_secure_ok_out(host_secure_ok_in));
   task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_tgt(input target_t got, input target_t exp);
      chk_val(64'(got), 64'(exp));
   endtask
   task automatic core(input logic [39:0] a, input target_t exp);
      @(negedge clk_in);
      req_valid_in = 1'b1;
      req_addr_in  = a;
      @(negedge clk_in);
      req_valid_in = 1'b0;
      chk_val(64'(out_valid_out), 64'h1);
      chk_tgt(out_target_out, exp);
      chk_val(64'(out_local_addr_out), 64'(a));
   endtask
   task automatic spt_wr(input logic [4:0] i, input logic [30:0] d);
      @(negedge clk_in);
      spt_wr_en_in    = 1'b1;
      spt_wr_index_in = i;
      spt_wr_data_in  = d;
      @(negedge clk_in);
      spt_wr_en_in = 1'b0;
   endtask
   task automatic test_local;
      core(40'h0000000040, TGT_MEM);
      core(40'h00fee00000, TGT_LIC);
      core(40'h00fee00fff, TGT_LIC);
      core(40'h00feffffff, TGT_MEM);
      core(40'h00ff000000, TGT_BOOT);
      core(40'h00ffffffff, TGT_BOOT);
      core(40'h05ffffffff, TGT_MEM);
      core(40'h0600000000, TGT_ERR);
      core(40'h08007c0000, TGT_CRU);
      core(40'h08007dffff, TGT_SIU);
      core(40'h0800000000, TGT_ERR);
      core(40'h0c00000000, TGT_ERR);
      core(40'h1000000000, TGT_ERR);
      core(40'h7fffffffff, TGT_ERR);
      $display("test_local done");
   endtask
   task automatic test_lic;
      @(negedge clk_in);
      lic_base_page_in = 28'h0001000;
      lic_base_load_in = 1'b1;
      @(negedge clk_in);
      lic_base_load_in = 1'b0;
      core(40'h0001000800, TGT_LIC);
      core(40'h00fee00000, TGT_MEM);
      $display("test_lic done");
   endtask
   task automatic test_sys;
      spt_wr(5'h01, {30'h12345678, 1'b0});
      spt_wr(5'h1f, {30'h3fffffff, 1'b1});
      core(40'h8400000123, TGT_HOST);
      chk_val(out_host_addr_out, {30'h12345678, 34'h000000123});
      chk_val(64'(out_no_snoop_out), 64'h0);
      core(40'hffffffffff, TGT_HOST);
      chk_val(out_host_addr_out, {30'h3fffffff, 34'h3ffffffff});
      chk_val(64'(out_no_snoop_out), 64'h1);
      $display("test_sys done");
   endtask
   task automatic test_host;
      host.send(64'h40_0000_0010, 1'b1, 1'b0);
      chk_val(64'(in_local_addr_out), 64'h0000100010);
      chk_tgt(in_target_out, TGT_MEM);
      chk_val(64'(in_valid_out), 64'h1);
      chk_val(64'(in_snoop_out), 64'h1);
      host.send(64'h40_0fff_fff0, 1'b0, 1'b0);
      chk_val(64'(in_local_addr_out), 64'h00100ffff0);
      chk_val(64'(in_snoop_out), 64'h0);
      host.send(64'h40_1000_0000, 1'b1, 1'b0);
      chk_tgt(in_target_out, TGT_ERR);
      pwin_size_sel_in = 3'h7;
      host.send(64'h47_ffff_ff00, 1'b1, 1'b0);
      chk_val(64'(in_local_addr_out), 64'h08000fff00);
      host.send(64'h50_0000_0000, 1'b0, 1'b0);
      chk_tgt(in_target_out, TGT_CRU);
      host.send(64'h50_0001_0000, 1'b0, 1'b1);
      chk_tgt(in_target_out, TGT_SIU);
      host.send(64'h50_0001_0000, 1'b0, 1'b0);
      chk_tgt(in_target_out, TGT_ERR);
      $display("test_host done");
   endtask
   task automatic print_verdict;
      $display("checks=%0d errors=%0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk_in);
      @(negedge clk_in);
      srst_in = 1'b0;
      test_local;
      test_lic;
      test_sys;
      test_host;
      print_verdict;
   end
   initial begin
      #100us;
      num_errors++;
      print_verdict;
   end
endmodule
`default_nettype wire
